// >>> src/pixel_port_defines.svh
// Register map, field positions, reset values and timing counts of the parallel pixel port
//
// Summary of operation
// - Parallel port stays disabled after power-up and reset until software enables it.
// - Enabled pins float only while enable pin high and drive bit clear; asynchronous.
// - Each pixel word is stable for sampling on the pixel clock rising edge.
// - Line valid is high only while the bus carries pixels of the current line.
// - Frame valid is high while the bus belongs to a frame being transferred.
// - Pixels leave as 12-bit words, bit 11 most significant, bit 0 least.
// - In default readout the first pixel of every frame is pixel (0,0).
// - Readout proceeds one complete row at a time, each row finished first.
// - Mirrored readout uses the extra column or row to keep the same colour start.
// - Readout is limited to 2048 columns per row; extra columns serve mirroring.
// - Active-low asynchronous reset restores every setting, port disabled.
// - Soft standby entry waits until the current parallel frame has ended.
`ifndef PIXEL_PORT_DEFINES_SVH
`define PIXEL_PORT_DEFINES_SVH

`define ADR_CTRL 8'h00
`define ADR_STATUS 8'h04
`define ADR_SIZE 8'h08

`define CTRL_SER_OFF 12
`define CTRL_PAR_EN 7
`define CTRL_DRIVE 6
`define CTRL_STBY 2
`define CTRL_MIR_H 14
`define CTRL_MIR_V 15
`define CTRL_MASK 32'h0000_D0C4
`define CTRL_RST 32'h0000_0000

`define SIZE_COLS_LSB 0
`define SIZE_ROWS_LSB 16
`define SIZE_RST 32'h0600_0800
`define MAX_COLS 12'h800

`define STAT_FRAME 0
`define STAT_STBY 1
`define STAT_EN 2

`define HBLANK_CYC 16'h0010
`define VBLANK_CYC 16'h0040

`endif

// >>> src/pixel_port_pkg.sv
// Types shared by the parallel pixel port
package pixel_port_pkg;

  // Pixel readout sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LINE = 2'b01,
    ST_HBLANK = 2'b10,
    ST_VBLANK = 2'b11
  } pix_state_t;

  // Configuration carried from the bus domain to the pixel domain
  typedef struct packed {
    logic par_en;
    logic drive;
    logic standby;
    logic mirror_h;
    logic mirror_v;
    logic [11:0] cols;
    logic [11:0] rows;
  } cfg_t;

  // Parallel output pins
  typedef struct packed {
    logic frame_valid;
    logic line_valid;
    logic [11:0] dout;
  } pin_bus_t;

endpackage : pixel_port_pkg

// >>> src/parallel_pixel_output_port.sv
// Parallel pixel output port with Wishbone control registers
`include "pixel_port_defines.svh"

module parallel_pixel_output_port (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic clk_pix,
  input wire logic output_enable_b,
  output logic pixel_out_clock,
  output pixel_port_pkg::pin_bus_t pins_o,
  output logic pins_oe
);
  import pixel_port_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions

  // Byte-lane merge of a write into a register
  function automatic logic [31:0] merge_sel(input logic [31:0] old_v, input logic [31:0] new_v,
                                            input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge_sel

  // Column count limited to 1..2048
  function automatic logic [11:0] clamp_cols(input logic [11:0] c);
    logic [11:0] r;
    r = c;
    if (c == 12'h000) begin
      r = 12'h001;
    end else if (c > `MAX_COLS) begin
      r = `MAX_COLS;
    end
    return r;
  endfunction : clamp_cols

  // Pixel word from array address; mirrored readout starts on the extra column or row
  function automatic logic [11:0] pixel_word(input logic [11:0] col, input logic [11:0] row,
                                             input logic [11:0] ncol, input logic [11:0] nrow,
                                             input logic mh, input logic mv);
    logic [11:0] ca;
    logic [11:0] ra;
    ca = mh ? ncol - col : col;
    ra = mv ? nrow - row : row;
    return {ra[5:0], ca[5:0]};
  endfunction : pixel_word

  ////////////////////////////////////////////////////////////////////////////
  // Bus domain registers

  logic [31:0] ctrl_q;
  logic [31:0] size_q;
  logic [2:0] stat_s1_q;
  logic [2:0] stat_s2_q;
  logic bus_wr;
  logic bus_req;
  logic ack_p_q;
  logic [2:0] stat_p_q;

  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign bus_wr = bus_req & wb_we_i;

  // Acknowledge every request one cycle after it appears
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end

  // Control and size registers; reset leaves the port disabled
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q <= `CTRL_RST;
      size_q <= `SIZE_RST;
    end else if (bus_wr) begin
      if (wb_adr_i == `ADR_CTRL) begin
        ctrl_q <= merge_sel(ctrl_q, wb_dat_i, wb_sel_i) & `CTRL_MASK;
      end else if (wb_adr_i == `ADR_SIZE) begin
        size_q <= merge_sel(size_q, wb_dat_i, wb_sel_i) & 32'h0FFF_0FFF;
      end
    end
  end

  // Read data; unmapped addresses read zero
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (bus_req && !wb_we_i) begin
      case (wb_adr_i)
        `ADR_CTRL: wb_dat_o <= ctrl_q;
        `ADR_STATUS: wb_dat_o <= {29'h0000_0000, stat_s2_q};
        `ADR_SIZE: wb_dat_o <= size_q;
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end else begin
      wb_dat_o <= 32'h0000_0000;
    end
  end

  // Port enable needs both serial-off and parallel-on bits
  logic port_en;
  assign port_en = ctrl_q[`CTRL_SER_OFF] & ctrl_q[`CTRL_PAR_EN];

  // Pin enable follows the enable pin with no clock in the path
  assign pins_oe = port_en & (~output_enable_b | ctrl_q[`CTRL_DRIVE]);

  ////////////////////////////////////////////////////////////////////////////
  // Configuration crossing to the pixel domain (toggle handshake)

  cfg_t cfg_live;
  cfg_t cfg_hold_q;
  logic req_q;
  logic ack_s1_q;
  logic ack_s2_q;

  always_comb begin
    cfg_live.par_en = port_en;
    cfg_live.drive = ctrl_q[`CTRL_DRIVE];
    cfg_live.standby = ctrl_q[`CTRL_STBY];
    cfg_live.mirror_h = ctrl_q[`CTRL_MIR_H];
    cfg_live.mirror_v = ctrl_q[`CTRL_MIR_V];
    cfg_live.cols = clamp_cols(size_q[`SIZE_COLS_LSB +: 12]);
    cfg_live.rows = (size_q[`SIZE_ROWS_LSB +: 12] == 12'h000) ? 12'h001 : size_q[`SIZE_ROWS_LSB +: 12];
  end

  // Hold word is only reloaded once the previous transfer is acknowledged
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cfg_hold_q <= '0;
      req_q <= 1'b0;
    end else if ((req_q == ack_s2_q) && (cfg_live != cfg_hold_q)) begin
      cfg_hold_q <= cfg_live;
      req_q <= ~req_q;
    end
  end

  // Acknowledge toggle and pixel status into the bus domain
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
      stat_s1_q <= 3'h0;
      stat_s2_q <= 3'h0;
    end else begin
      ack_s1_q <= ack_p_q;
      ack_s2_q <= ack_s1_q;
      stat_s1_q <= stat_p_q;
      stat_s2_q <= stat_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pixel domain

  logic rst_p1_q;
  logic rst_pix_b;
  logic req_p1_q;
  logic req_p2_q;
  cfg_t cfg_p_q;

  // Reset for the pixel domain: asserts at once, releases on its own clock
  always_ff @(posedge clk_pix or negedge rst_b) begin
    if (!rst_b) begin
      rst_p1_q <= 1'b0;
      rst_pix_b <= 1'b0;
    end else begin
      rst_p1_q <= 1'b1;
      rst_pix_b <= rst_p1_q;
    end
  end

  // Capture the held configuration when a new request toggle arrives
  always_ff @(posedge clk_pix or negedge rst_pix_b) begin
    if (!rst_pix_b) begin
      req_p1_q <= 1'b0;
      req_p2_q <= 1'b0;
      ack_p_q <= 1'b0;
      cfg_p_q <= '0;
    end else begin
      req_p1_q <= req_q;
      req_p2_q <= req_p1_q;
      if (req_p2_q != ack_p_q) begin
        cfg_p_q <= cfg_hold_q;
        ack_p_q <= req_p2_q;
      end
    end
  end

  // Pixel clock out at half the link rate; data moves on its falling edge
  logic phase_q;
  logic step;
  assign step = phase_q;

  always_ff @(posedge clk_pix or negedge rst_pix_b) begin
    if (!rst_pix_b) begin
      phase_q <= 1'b0;
      pixel_out_clock <= 1'b0;
    end else begin
      phase_q <= ~phase_q;
      pixel_out_clock <= ~phase_q;
    end
  end

  // Readout sequencer
  pix_state_t state_q;
  logic [11:0] col_q;
  logic [11:0] row_q;
  logic [15:0] cnt_q;
  logic [11:0] fcols_q;
  logic [11:0] frows_q;
  logic fmh_q;
  logic fmv_q;

  // Outputs change only on steps, so they hold across every rising edge
  always_ff @(posedge clk_pix or negedge rst_pix_b) begin
    if (!rst_pix_b) begin
      state_q <= ST_IDLE;
      col_q <= 12'h000;
      row_q <= 12'h000;
      cnt_q <= 16'h0000;
      fcols_q <= `MAX_COLS;
      frows_q <= 12'h001;
      fmh_q <= 1'b0;
      fmv_q <= 1'b0;
      pins_o <= '0;
    end else if (step) begin
      case (state_q)
        ST_IDLE: begin
          pins_o <= '0;
          if (cfg_p_q.par_en && !cfg_p_q.standby) begin
            fcols_q <= cfg_p_q.cols;
            frows_q <= cfg_p_q.rows;
            fmh_q <= cfg_p_q.mirror_h;
            fmv_q <= cfg_p_q.mirror_v;
            col_q <= 12'h000;
            row_q <= 12'h000;
            pins_o.frame_valid <= 1'b1;
            pins_o.line_valid <= 1'b1;
            pins_o.dout <= pixel_word(12'h000, 12'h000, cfg_p_q.cols, cfg_p_q.rows,
                                      cfg_p_q.mirror_h, cfg_p_q.mirror_v);
            state_q <= ST_LINE;
          end
        end
        ST_LINE: begin
          if (col_q == fcols_q - 12'h001) begin
            pins_o.line_valid <= 1'b0;
            pins_o.dout <= 12'h000;
            cnt_q <= 16'h0000;
            state_q <= ST_HBLANK;
          end else begin
            col_q <= col_q + 12'h001;
            pins_o.dout <= pixel_word(col_q + 12'h001, row_q, fcols_q, frows_q, fmh_q, fmv_q);
          end
        end
        ST_HBLANK: begin
          cnt_q <= cnt_q + 16'h0001;
          if (cnt_q == `HBLANK_CYC - 16'h0001) begin
            cnt_q <= 16'h0000;
            if (row_q == frows_q - 12'h001) begin
              pins_o.frame_valid <= 1'b0;
              state_q <= ST_VBLANK;
            end else begin
              row_q <= row_q + 12'h001;
              col_q <= 12'h000;
              pins_o.line_valid <= 1'b1;
              pins_o.dout <= pixel_word(12'h000, row_q + 12'h001, fcols_q, frows_q, fmh_q, fmv_q);
              state_q <= ST_LINE;
            end
          end
        end
        ST_VBLANK: begin
          cnt_q <= cnt_q + 16'h0001;
          if (cnt_q == `VBLANK_CYC - 16'h0001) begin
            cnt_q <= 16'h0000;
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
          pins_o <= '0;
        end
      endcase
    end
  end

  // Pixel status: standby only reported once the frame is over
  always_ff @(posedge clk_pix or negedge rst_pix_b) begin
    if (!rst_pix_b) begin
      stat_p_q <= 3'h0;
    end else begin
      stat_p_q[`STAT_FRAME] <= (state_q != ST_IDLE);
      stat_p_q[`STAT_STBY] <= (state_q == ST_IDLE) & cfg_p_q.standby;
      stat_p_q[`STAT_EN] <= cfg_p_q.par_en;
    end
  end

endmodule : parallel_pixel_output_port

// >>> verification/pixel_port_checker.sv
// Checker of the pixel port pins and bus answer
module pixel_port_checker (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic clk_pix,
  input wire logic output_enable_b,
  input wire logic pixel_out_clock,
  input wire pixel_port_pkg::pin_bus_t pins_o,
  input wire logic pins_oe
);
  import pixel_port_pkg::*;
  // End of a line as seen by the receiver
  sequence s_line_end;
    $fell(pins_o.line_valid);
  endsequence
  chk_ack_pulse: assert property (@(posedge clk_sys) disable iff (!rst_b)
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o) else $error("ack not one pulse");
  chk_reset_quiet: assert property (@(posedge clk_sys) disable iff (!rst_b)
    $rose(rst_b) |-> !pins_oe && pins_o == '0) else $error("port active after reset");
  chk_oe_frame: assert property (@(posedge clk_pix) disable iff (!rst_b)
    pins_o.frame_valid && !output_enable_b |-> pins_oe) else $error("pins float with enable low");
  chk_word_hold: assert property (@(posedge clk_pix) disable iff (!rst_b)
    pixel_out_clock |-> $stable(pins_o)) else $error("pins change at clock rise");
  chk_line_in_frame: assert property (@(posedge clk_pix) disable iff (!rst_b)
    pins_o.line_valid |-> pins_o.frame_valid) else $error("line valid outside frame");
  chk_dout_blank: assert property (@(posedge clk_pix) disable iff (!rst_b)
    !pins_o.line_valid |-> pins_o.dout == 12'h000) else $error("data outside line");
  chk_hblank_gap: assert property (@(posedge pixel_out_clock) disable iff (!rst_b)
    s_line_end |-> (!pins_o.line_valid) [*8]) else $error("line gap too short");
  chk_line_tail: assert property (@(posedge pixel_out_clock) disable iff (!rst_b)
    s_line_end |-> pins_o.frame_valid) else $error("frame ended inside line");
  chk_frame_open: assert property (@(posedge pixel_out_clock) disable iff (!rst_b)
    $rose(pins_o.frame_valid) |-> pins_o.line_valid) else $error("frame starts without pixel");
endmodule : pixel_port_checker

bind parallel_pixel_output_port pixel_port_checker i_pixel_port_checker (.*);

// >>> verification/pixel_rx_model.sv
// Capture receiver model sampling on the pixel clock rise
module pixel_rx_model (
  input wire logic pixel_out_clock,
  input wire pixel_port_pkg::pin_bus_t pins,
  input wire logic pins_oe,
  output int frames,
  output logic [11:0] first_w,
  output int n_cols,
  output int n_lines
);
  timeunit 1ns;
  timeprecision 100ps;
  import pixel_port_pkg::*;
  bit in_f;
  bit in_l;
  bit first;
  int cnt;
  initial frames = 0;
  // Floating pins are not sampled
  always @(posedge pixel_out_clock) begin
    if (pins_oe) begin
      if (pins.frame_valid && !in_f) begin
        in_f = 1;
        first = 1;
        n_lines = 0;
      end
      if (pins.line_valid) begin
        if (!in_l) begin
          if (first) first_w = pins.dout;
          first = 0;
          cnt = 0;
          in_l = 1;
        end
        cnt++;
      end else if (in_l) begin
        in_l = 0;
        n_cols = cnt;
        n_lines++;
      end
      if (!pins.frame_valid && in_f) begin
        in_f = 0;
        frames++;
      end
    end
  end
endmodule : pixel_rx_model

// >>> verification/tb.sv
// Testbench of the parallel pixel output port
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import pixel_port_pkg::*;
  logic clk_sys = 0;
  logic clk_pix = 0;
  logic rst_b = 0;
  logic cyc = 0;
  logic stb = 0;
  logic we = 0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic oe_b = 0;
  logic pixel_out_clock;
  pin_bus_t pins;
  logic pins_oe;
  int frames;
  int n_cols;
  int n_lines;
  logic [11:0] first_w;
  int n_mismatch = 0;
  int n_compared = 0;
  int n_cyc = 0;
  int f;

  initial forever #5 clk_sys = ~clk_sys;
  initial begin
    #17;
    forever #62.5 clk_pix = ~clk_pix;
  end

  parallel_pixel_output_port i_parallel_pixel_output_port (
    .clk_sys(clk_sys), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .clk_pix(clk_pix), .output_enable_b(oe_b), .pixel_out_clock(pixel_out_clock),
    .pins_o(pins), .pins_oe(pins_oe)
  );
  pixel_rx_model i_pixel_rx_model (
    .pixel_out_clock(pixel_out_clock), .pins(pins), .pins_oe(pins_oe),
    .frames(frames), .first_w(first_w), .n_cols(n_cols), .n_lines(n_lines)
  );

  ////////////////////////////////////////////////////////////////
  // Verdict and hang guard
  task test_done;
    if (n_mismatch == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : test_done
  always @(posedge clk_sys) begin
    n_cyc++;
    if (n_cyc == 60000) begin
      n_mismatch++;
      test_done;
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One classic Wishbone cycle, held until ack
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
    rdat = wb_dat_o;
    cyc <= 0;
    stb <= 0;
  endtask : wb
  task wait_frame;
    f = frames;
    wait (frames != f);
  endtask : wait_frame

  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (5) @(posedge clk_sys);
    rst_b <= 1;
    @(posedge clk_sys);
    chk(pins_oe, 0);
    wb(0, 8'h00, 0);
    chk(rdat, 32'h0);
    wb(0, 8'h08, 0);
    chk(rdat, 32'h0600_0800);
    wb(0, 8'h04, 0);
    chk(rdat & 32'h4, 32'h0);
    wb(0, 8'h0C, 0);
    chk(rdat, 32'h0);
    wb(1, 8'h08, 32'h0003_0004);
    // Parallel bit alone leaves the port off
    wb(1, 8'h00, 32'h0000_0080);
    repeat (200) @(posedge clk_sys);
    chk(pins_oe, 0);
    chk(frames, 0);
    // Plain then mirrored readout in both directions
    for (int m = 0; m < 2; m++) begin
      wb(1, 8'h00, 32'h0000_1080 | (m << 14) | (m << 15));
      wait_frame;
      if (m == 1) wait_frame;
      chk(first_w, m ? 12'h0C4 : 12'h000);
      chk(n_cols, 4);
      chk(n_lines, 3);
    end
    @(posedge clk_sys);
    oe_b <= 1;
    #1;
    chk(pins_oe, 0);
    wb(1, 8'h00, 32'h0000_10C0);
    repeat (100) @(posedge clk_sys);
    chk(pins_oe, 1);
    oe_b <= 0;
    // Standby request in mid-frame
    wait (pins.line_valid === 1'b1);
    wb(1, 8'h00, 32'h0000_1084);
    wait_frame;
    chk(n_lines, 3);
    // Vertical blanking must run out before standby shows
    repeat (2000) @(posedge clk_sys);
    wb(0, 8'h04, 0);
    chk(rdat & 32'h3, 32'h2);
    chk(frames, f + 1);
    // Second reset in mid-run restores the defaults
    rst_b <= 0;
    repeat (30) @(posedge clk_sys);
    rst_b <= 1;
    @(posedge clk_sys);
    chk(pins_oe, 0);
    wb(0, 8'h00, 0);
    chk(rdat, 32'h0);
    test_done;
  end
endmodule : tb
